// *** spicc_pkg.sv ***
// package: register map, control fields, reset values and shared types of the spi port
package spicc_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_STATUS  = 32'hFFFF0A00;
	localparam logic [31:0] ADDR_RX      = 32'hFFFF0A04;
	localparam logic [31:0] ADDR_TX      = 32'hFFFF0A08;
	localparam logic [31:0] ADDR_DIV     = 32'hFFFF0A0C;
	localparam logic [31:0] ADDR_CONTROL = 32'hFFFF0A10;
	localparam logic [31:0] ADDR_IRQ_EN  = 32'hFFFF0A14;
	localparam logic [31:0] ADDR_IRQ_CLR = 32'hFFFF0A18;

	// control field positions
	localparam int CTL_EN      = 0;
	localparam int CTL_MASTER  = 1;
	localparam int CTL_CPHA    = 2;
	localparam int CTL_CPOL    = 3;
	localparam int CTL_LSB     = 5;
	localparam int CTL_TXMODE  = 6;
	localparam int CTL_UNDREP  = 7;
	localparam int CTL_OVWR    = 8;
	localparam int CTL_SSOE    = 9;

	// status field positions
	localparam int ST_TXBUSY = 0;
	localparam int ST_TXIRQ  = 1;
	localparam int ST_TXUND  = 2;
	localparam int ST_RXFULL = 3;
	localparam int ST_RXIRQ  = 4;
	localparam int ST_RXOVF  = 5;

	// values after reset, and bits per transfer
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam logic [7:0]  DIV_RST     = 8'h1B;
	localparam logic [7:0]  RX_RST      = 8'h00;
	localparam logic [3:0]  BITS_PER_XFER = 4'h8;

	// event bits for the interrupt status
	localparam int EV_DONE = 0;
	localparam int EV_UND  = 1;
	localparam int EV_OVF  = 2;
	localparam int EV_W    = 3;

	// configuration carried to the shift engine
	typedef struct packed {
		logic enable;
		logic master;
		logic cpha;
		logic cpol;
		logic lsb_first;
	} spicc_cfg_t;

	// spi pin group seen at the block boundary
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic ss_n;
	} spicc_pins_t;

endpackage

// *** spicc_sync.sv ***
// two flip-flop synchroniser for the spi pin inputs
module spicc_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// next stage values, first stage read only by the second
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule

// *** spicc_clkdiv.sv ***
// bit rate divider giving one-cycle half-period enables
module spicc_clkdiv (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// control
	input  wire logic       run,
	input  wire logic [7:0] divisor,
	output logic            half_tick
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       tick_q;
	logic       tick_d;

	// count divisor+1 cycles per half period of the serial clock
	always_comb
	begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (!run)
			cnt_d = 8'h00;
		else if (cnt_q >= divisor)
		begin
			cnt_d  = 8'h00;
			tick_d = 1'b1;
		end
		else
			cnt_d = cnt_q + 8'h01;
	end

	// register counter and pulse
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cnt_q  <= 8'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign half_tick = tick_q;

endmodule

// *** spicc_top.sv ***
// spi port: registers, configuration, master and slave shift engine, interrupt
module spicc_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// spi pins, enables low while driving
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe_n,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_n,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_n,
	input  wire logic        ss_n_in,
	output logic             ss_n_out,
	output logic             ss_oe_n,
	// interrupt
	output logic             irq
);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b10
	} spicc_state_t;

	spicc_pkg::spicc_cfg_t  cfg;
	spicc_pkg::spicc_pins_t pins_s;

	logic [15:0] ctl_q, ctl_d;
	logic [7:0]  div_q, div_d;
	logic [7:0]  tx_q, tx_d;
	logic [7:0]  last_q, last_d;
	logic [7:0]  rx_q, rx_d;
	logic [7:0]  st_q, st_d;
	logic [3:0]  ev_q, ev_d;
	logic [3:0]  ien_q, ien_d;
	logic [15:0] rdata_q, rdata_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  in_q, in_d;
	logic [3:0]  bit_q, bit_d;
	logic        ph_q, ph_d;
	logic        sclk_q, sclk_d;
	logic        sso_q, sso_d;
	logic        sclk_prev_q;
	logic        go_q, go_d;
	spicc_state_t state_q, state_d;

	logic       half_tick;
	logic       wr_tx, rd_rx, wr_ctl, wr_div, wr_ien, wr_clr;
	logic       byte_done;
	logic [7:0] byte_in;
	logic       lead_edge, trail_edge, sclk_rise, sclk_fall;

	// pick bit to send next for the configured order
	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[7];
	endfunction

	// address decode shared by strobes and read mux
	function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
		hit = (a == b);
	endfunction

	// pin synchronisers
	spicc_sync #(
		.WIDTH (4)
	) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in ({sclk_in, mosi_in, miso_in, ss_n_in}),
		.sync_out (pins_s)
	);

	// master bit clock
	spicc_clkdiv u_div (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.run       (state_q == ST_SHIFT && cfg.master),
		.divisor   (div_q),
		.half_tick (half_tick)
	);

	assign cfg.enable    = ctl_q[spicc_pkg::CTL_EN];
	assign cfg.master    = ctl_q[spicc_pkg::CTL_MASTER];
	assign cfg.cpha      = ctl_q[spicc_pkg::CTL_CPHA];
	assign cfg.cpol      = ctl_q[spicc_pkg::CTL_CPOL];
	assign cfg.lsb_first = ctl_q[spicc_pkg::CTL_LSB];

	// register strobes
	assign wr_tx  = reg_wr && hit(reg_addr, spicc_pkg::ADDR_TX);
	assign wr_ctl = reg_wr && hit(reg_addr, spicc_pkg::ADDR_CONTROL);
	assign wr_div = reg_wr && hit(reg_addr, spicc_pkg::ADDR_DIV);
	assign wr_ien = reg_wr && hit(reg_addr, spicc_pkg::ADDR_IRQ_EN);
	assign wr_clr = reg_wr && hit(reg_addr, spicc_pkg::ADDR_IRQ_CLR);
	assign rd_rx  = reg_rd && hit(reg_addr, spicc_pkg::ADDR_RX);

	// slave-side edge detect on the synchronised clock, cpol folds polarity
	assign sclk_rise  = pins_s.sclk && !sclk_prev_q;
	assign sclk_fall  = !pins_s.sclk && sclk_prev_q;
	// idle level picks which pin edge leads
	assign lead_edge  = cfg.cpol ? sclk_fall : sclk_rise;
	assign trail_edge = cfg.cpol ? sclk_rise : sclk_fall;

	// received byte in the configured order
	// bit order on receive
	assign byte_in = cfg.lsb_first ? {in_q[0], in_q[1], in_q[2], in_q[3], in_q[4], in_q[5], in_q[6], in_q[7]}
		: in_q;
	assign byte_done = (state_q == ST_DONE);

	// shift engine next state
	always_comb
	begin
		state_d = state_q;
		sh_d    = sh_q;
		in_d    = in_q;
		bit_d   = bit_q;
		ph_d    = ph_q;
		sclk_d  = sclk_q;
		sso_d   = 1'b1;
		unique case (state_q)
			ST_IDLE:
			begin
				sclk_d = cfg.cpol;
				bit_d  = 4'h0;
				ph_d   = 1'b0;
				if (cfg.enable && ((cfg.master && go_q) || (!cfg.master && !pins_s.ss_n)))
				begin
					state_d = ST_SHIFT;
					// underflow resends last byte or zero
					if (st_q[spicc_pkg::ST_TXBUSY])
						sh_d = tx_q;
					else
						sh_d = ctl_q[spicc_pkg::CTL_UNDREP] ? last_q : 8'h00;
					// reorder so bit 7 always leaves first
					if (cfg.lsb_first)
						sh_d = {sh_d[0], sh_d[1], sh_d[2], sh_d[3], sh_d[4], sh_d[5], sh_d[6], sh_d[7]};
				end
			end
			ST_SHIFT:
			begin
				if (cfg.master)
				begin
					sso_d = !cfg.enable; // select rises at once when disabled mid-byte
					if (half_tick)
					begin
						// phase decides toggle before or after the sample
						sclk_d = ~sclk_q;
						ph_d   = ~ph_q;
						if (!ph_q)
						begin
							if (cfg.cpha)
								sh_d = (bit_q == 4'h0) ? sh_q : {sh_q[6:0], 1'b0};
							else
								in_d = {in_q[6:0], pins_s.miso};
						end
						else
						begin
							if (cfg.cpha)
								in_d = {in_q[6:0], pins_s.miso};
							else
								sh_d = {sh_q[6:0], 1'b0};
							bit_d = bit_q + 4'h1;
							if (bit_q == spicc_pkg::BITS_PER_XFER - 4'h1)
							begin
								state_d = ST_DONE;
								sclk_d  = cfg.cpol;
							end
						end
					end
				end
				else
				begin
					// select rising ends the slave transfer
					if (pins_s.ss_n)
						state_d = ST_IDLE;
					else if (cfg.cpha ? trail_edge : lead_edge)
					begin
						in_d  = {in_q[6:0], pins_s.mosi};
						bit_d = bit_q + 4'h1;
						if (bit_q == spicc_pkg::BITS_PER_XFER - 4'h1)
							state_d = ST_DONE;
					end
					else if (cfg.cpha ? (lead_edge && bit_q != 4'h0) : trail_edge)
						sh_d = {sh_q[6:0], 1'b0};
				end
				if (!cfg.enable)
					state_d = ST_IDLE;
			end
			ST_DONE:
			begin
				sclk_d = cfg.cpol;
				// slave waits for select release before a new byte
				if (cfg.master || pins_s.ss_n)
					state_d = ST_IDLE;
				else
					state_d = ST_DONE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	// register file and status next values
	always_comb
	begin
		ctl_d = wr_ctl ? reg_wdata : ctl_q;
		div_d = wr_div ? reg_wdata[7:0] : div_q;
		ien_d = wr_ien ? reg_wdata[3:0] : ien_q;
		tx_d   = wr_tx ? reg_wdata[7:0] : tx_q;
		last_d = last_q;
		rx_d   = rx_q;
		st_d   = st_q;
		go_d   = go_q;
		ev_d   = ev_q;
		if (wr_clr)
			ev_d = ev_q & ~reg_wdata[3:0];
		// transmit write starts a master transfer
		if (wr_tx)
		begin
			st_d[spicc_pkg::ST_TXBUSY] = 1'b1;
			st_d[spicc_pkg::ST_TXUND]  = 1'b0;
			if (cfg.master && ctl_q[spicc_pkg::CTL_TXMODE])
				go_d = 1'b1;
		end
		// receive read starts a master transfer
		if (rd_rx)
		begin
			st_d[spicc_pkg::ST_RXFULL] = 1'b0;
			st_d[spicc_pkg::ST_RXOVF]  = 1'b0;
			if (cfg.master && !ctl_q[spicc_pkg::CTL_TXMODE])
				go_d = 1'b1;
		end
		if (state_q == ST_IDLE && state_d == ST_SHIFT)
		begin
			go_d = cfg.master && (wr_tx && ctl_q[spicc_pkg::CTL_TXMODE] || rd_rx && !ctl_q[spicc_pkg::CTL_TXMODE]);
			if (st_q[spicc_pkg::ST_TXBUSY])
			begin
				last_d = tx_q;
				st_d[spicc_pkg::ST_TXBUSY] = wr_tx; // a write in the launch cycle stays pending
			end
			else
			begin
				st_d[spicc_pkg::ST_TXUND] = 1'b1;
				ev_d[spicc_pkg::EV_UND]   = 1'b1;
			end
		end
		if (byte_done && state_d == ST_IDLE) // slave byte lands once, when select rises
		begin
			ev_d[spicc_pkg::EV_DONE] = 1'b1;
			// overflow overwrites or drops the new byte
			if (st_q[spicc_pkg::ST_RXFULL] && !rd_rx)
			begin
				st_d[spicc_pkg::ST_RXOVF] = 1'b1;
				ev_d[spicc_pkg::EV_OVF]   = 1'b1;
				if (ctl_q[spicc_pkg::CTL_OVWR])
					rx_d = byte_in;
			end
			else
			begin
				rx_d = byte_in;
				st_d[spicc_pkg::ST_RXFULL] = 1'b1;
			end
		end
		if (!cfg.enable)
			go_d = 1'b0;
		// tx irq when transmit register empty
		st_d[spicc_pkg::ST_TXIRQ] = cfg.enable && (!st_d[spicc_pkg::ST_TXBUSY] || st_d[spicc_pkg::ST_TXUND]);
		// rx irq when receive register full
		st_d[spicc_pkg::ST_RXIRQ] = st_d[spicc_pkg::ST_RXFULL] || st_d[spicc_pkg::ST_RXOVF];
		st_d[7:6] = 2'b00;
		ev_d[spicc_pkg::EV_W] = ctl_q[spicc_pkg::CTL_TXMODE] ? st_d[spicc_pkg::ST_TXIRQ]
			: st_d[spicc_pkg::ST_RXIRQ];
	end

	// read mux, data valid the cycle after the strobe
	always_comb
	begin
		rdata_d = 16'h0000;
		if (reg_rd)
		begin
			if (hit(reg_addr, spicc_pkg::ADDR_STATUS))
				rdata_d = {8'h00, st_q};
			else if (hit(reg_addr, spicc_pkg::ADDR_RX))
				rdata_d = {8'h00, rx_q};
			else if (hit(reg_addr, spicc_pkg::ADDR_DIV))
				rdata_d = {8'h00, div_q};
			else if (hit(reg_addr, spicc_pkg::ADDR_CONTROL))
				rdata_d = ctl_q;
			else if (hit(reg_addr, spicc_pkg::ADDR_IRQ_EN))
				rdata_d = {12'h000, ien_q};
		end
	end

	// register all state
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctl_q       <= spicc_pkg::CONTROL_RST;
			div_q       <= spicc_pkg::DIV_RST;
			tx_q        <= 8'h00;
			last_q      <= 8'h00;
			rx_q        <= spicc_pkg::RX_RST;
			st_q        <= spicc_pkg::STATUS_RST;
			ev_q        <= 4'h0;
			ien_q       <= 4'h0;
			rdata_q     <= 16'h0000;
			sh_q        <= 8'h00;
			in_q        <= 8'h00;
			bit_q       <= 4'h0;
			ph_q        <= 1'b0;
			sclk_q      <= 1'b0;
			sso_q       <= 1'b1;
			sclk_prev_q <= 1'b0;
			go_q        <= 1'b0;
			state_q     <= ST_IDLE;
		end
		else
		begin
			ctl_q       <= ctl_d;
			div_q       <= div_d;
			tx_q        <= tx_d;
			last_q      <= last_d;
			rx_q        <= rx_d;
			st_q        <= st_d;
			ev_q        <= ev_d;
			ien_q       <= ien_d;
			rdata_q     <= rdata_d;
			sh_q        <= sh_d;
			in_q        <= in_d;
			bit_q       <= bit_d;
			ph_q        <= ph_d;
			sclk_q      <= sclk_d;
			sso_q       <= sso_d;
			sclk_prev_q <= pins_s.sclk;
			go_q        <= go_d;
			state_q     <= state_d;
		end
	end

	// pin drive: master drives clock, mosi when enabled, and select when ssoe is set; slave drives miso when enabled and selected
	assign reg_rdata = rdata_q;
	// disabled master still drives clock at idle level
	assign sclk_out  = cfg.enable ? sclk_q : cfg.cpol;
	assign sclk_oe_n = !cfg.master;
	assign mosi_out  = sh_q[7];
	assign mosi_oe_n = !(cfg.master && cfg.enable);
	assign miso_out  = out_bit(sh_q, 1'b0);
	assign miso_oe_n = !(!cfg.master && cfg.enable && !pins_s.ss_n);
	assign ss_n_out  = sso_q;
	assign ss_oe_n   = !(cfg.master && ctl_q[spicc_pkg::CTL_SSOE]);
	assign irq       = |(ev_q & ien_q);

endmodule

// *** spicc_assertions.sv ***
// checker: port-level assertions for the spi port
module spicc_assertions (
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// pins and interrupt
	input wire logic        sclk_out,
	input wire logic        sclk_oe_n,
	input wire logic        mosi_oe_n,
	input wire logic        ss_n_out,
	input wire logic        ss_oe_n,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [15:0] ctl_q, ctl_d, ctlp_q;
	logic [4:0]  tog_q, tog_d;
	logic        sclkp_q, st, en, mst;
	// control shadow and clock edges seen within a frame
	always_comb
	begin
		ctl_d = (reg_wr && reg_addr == spicc_pkg::ADDR_CONTROL) ? reg_wdata : ctl_q;
		tog_d = ss_n_out ? 5'h00 : tog_q + 5'(sclk_out != sclkp_q);
	end
	always_ff @(posedge clk)
	begin
		ctl_q   <= sys_rst ? 16'h0000 : ctl_d;
		ctlp_q  <= sys_rst ? 16'h0000 : ctl_q;
		tog_q   <= sys_rst ? 5'h00 : tog_d;
		sclkp_q <= sclk_out;
	end
	// settings held for a cycle, so outputs have caught up
	assign st  = ctl_q == ctlp_q;
	assign en  = ctl_q[spicc_pkg::CTL_EN];
	assign mst = ctl_q[spicc_pkg::CTL_MASTER];

	chk_sclk_dir: assert property (st |-> sclk_oe_n == !mst)
		else $error("serial clock direction does not follow role");
	chk_mosi_dir: assert property (st |-> mosi_oe_n == !(en && mst))
		else $error("data out enable does not follow enable and role");
	chk_ss_dir: assert property (st |-> ss_oe_n == !(mst && ctl_q[spicc_pkg::CTL_SSOE]))
		else $error("select output enable wrong");
	chk_idle_off: assert property (st && !en |-> ss_n_out && (!mst || sclk_out == ctl_q[spicc_pkg::CTL_CPOL]))
		else $error("disabled port is active");
	chk_clk_idle: assert property (st && en && mst && ss_n_out && $past(ss_n_out)
		|-> sclk_out == ctl_q[spicc_pkg::CTL_CPOL])
		else $error("serial clock not at idle level");
	chk_bit_count: assert property ($rose(ss_n_out) |-> (tog_q + 5'(sclk_out != sclkp_q)) == 5'h10)
		else $error("frame does not hold sixteen clock edges");
	chk_frame_len: assert property ($fell(ss_n_out) |-> !ss_n_out [*8] ##[1:1000] ss_n_out)
		else $error("frame length out of range");
	chk_tx_start: assert property (reg_wr && reg_addr == spicc_pkg::ADDR_TX && st && en && mst
		&& ctl_q[spicc_pkg::CTL_TXMODE] && ss_n_out |-> ##[1:4] !ss_n_out)
		else $error("transmit write did not start a frame");
	chk_rx_start: assert property (reg_rd && reg_addr == spicc_pkg::ADDR_RX && st && en && mst
		&& !ctl_q[spicc_pkg::CTL_TXMODE] && ss_n_out |-> ##[1:4] !ss_n_out)
		else $error("receive read did not start a frame");
	chk_read_width: assert property (reg_rd && reg_addr != spicc_pkg::ADDR_CONTROL
		|=> reg_rdata[15:8] == 8'h00)
		else $error("byte register read has upper bits set");
	chk_irq_mask: assert property (reg_wr && reg_addr == spicc_pkg::ADDR_IRQ_EN && reg_wdata[3:0] == 4'h0
		##1 !(reg_wr && reg_addr == spicc_pkg::ADDR_IRQ_EN) |-> ##1 !irq)
		else $error("interrupt high with all sources masked");
endmodule

// *** spicc_partner.sv ***
// partner: behavioural spi device on the far side of the port
module spicc_partner (
	// wire levels
	input wire logic       sclk,
	input wire logic       ss_n,
	input wire logic       din,
	// frame format
	input wire logic       cpol,
	input wire logic       cpha,
	input wire logic       lsb,
	input wire logic [7:0] tx,
	// driven levels and received byte
	output logic           m_sclk,
	output logic           m_ss_n,
	output logic           sbit,
	output logic [7:0]     rx
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	// idle levels
	initial
	begin
		m_sclk = 1'b0;
		m_ss_n = 1'b1;
		sbit   = 1'b0;
		rx     = 8'h00;
		n      = 8;
	end
	// outgoing bit in wire order
	function automatic logic pick(input int i);
		return lsb ? tx[i] : tx[7 - i];
	endfunction
	// select low opens a frame, phase 0 shows bit one at once
	always @(negedge ss_n)
	begin
		n = 0;
		if (!cpha)
			sbit = pick(0);
	end
	// sample on one clock edge, drive on the other
	always @(sclk)
	begin
		if (!ss_n && n < 8)
		begin
			if ((sclk != cpol) != cpha)
			begin
				rx = lsb ? {din, rx[7:1]} : {rx[6:0], din};
				n++;
			end
			else
				sbit = pick(n);
		end
	end
	// released line shows the inverse of its last level
	always @(posedge ss_n)
		sbit = ~sbit;
	// master frame: select low, eight clock periods, select high
	task master_xfer;
		// step off the core clock edge so the synchroniser never races the pins
		#10;
		m_sclk = cpol;
		m_ss_n = 1'b0;
		#400;
		repeat (16)
		begin
			m_sclk = ~m_sclk;
			#200;
		end
		m_ss_n = 1'b1;
		#400;
	endtask
endmodule

// *** spicc_top_bench.sv ***
// testbench: register and serial traffic checks for the spi port
module spicc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, sys_rst, reg_wr, reg_rd, irq;
	logic [31:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic        sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_n_out, ss_oe_n;
	logic        p_sclk, p_ss_n, p_bit, p_master, cpol, cpha, lsb;
	logic [7:0]  p_tx, p_rx;
	int          mismatches, checks;
	// wire levels from whichever party drives
	wire sclk_w = sclk_oe_n ? p_sclk : sclk_out;
	wire ss_w   = ss_oe_n ? p_ss_n : ss_n_out;
	wire mosi_w = mosi_oe_n ? p_bit : mosi_out;
	wire miso_w = miso_oe_n ? p_bit : miso_out;

	spicc_top spicc_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_in(sclk_w), .sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_w),
		.ss_n_out(ss_n_out), .ss_oe_n(ss_oe_n), .irq(irq));
	spicc_partner spicc_partner_inst (.sclk(sclk_w), .ss_n(ss_w), .din(p_master ? miso_w : mosi_w),
		.cpol(cpol), .cpha(cpha), .lsb(lsb), .tx(p_tx), .m_sclk(p_sclk), .m_ss_n(p_ss_n),
		.sbit(p_bit), .rx(p_rx));

	// clock
	initial
	begin
		clk = 1'b0;
		forever
			#25 clk = ~clk;
	end

	task conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input string n, input logic [31:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		chk(n, e, v);
	endtask
	// wait for a master frame to open and close
	task waitx;
		int i, j;
		i = 0;
		j = 0;
		while (ss_n_out === 1'b1 && i < 40)
		begin
			@(posedge clk);
			i++;
		end
		while (ss_n_out === 1'b0 && j < 2000)
		begin
			@(posedge clk);
			j++;
		end
		if (i == 40 || j == 2000)
		begin
			mismatches++;
			$display("FAIL frame expected done seen timeout");
			conclude;
		end
		repeat (4) @(posedge clk);
	endtask
	task send(input logic [7:0] b, input logic [7:0] d);
		p_tx = b;
		wr(spicc_pkg::ADDR_TX, {8'h00, d});
		waitx;
	endtask
	task irqc(input string n, input logic [31:0] a, input logic [15:0] d, input logic e);
		wr(a, d);
		repeat (2) @(posedge clk);
		chk(n, {15'h0000, e}, {15'h0000, irq});
	endtask

	// main sequence
	initial
	begin
		{sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 50'h0};
		{p_master, cpol, cpha, lsb, p_tx, mismatches, checks} = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rdc("status", spicc_pkg::ADDR_STATUS, 16'h0000); // reset value
		rdc("control", spicc_pkg::ADDR_CONTROL, 16'h0000); // disabled slave after reset
		rdc("divider", spicc_pkg::ADDR_DIV, 16'h001B);
		wr(spicc_pkg::ADDR_STATUS, 16'h00FF);
		rdc("status_ro", spicc_pkg::ADDR_STATUS, 16'h0000); // read only
		rdc("unmapped", 32'hFFFF0A1C, 16'h0000);
		// half period must exceed the two-cycle input synchroniser delay
		wr(spicc_pkg::ADDR_DIV, 16'h0005);
		wr(spicc_pkg::ADDR_IRQ_EN, 16'h0001);
		// master frames in every clock mode and bit order
		for (int m = 0; m < 8; m++)
		begin
			{lsb, cpol, cpha} = 3'(m);
			wr(spicc_pkg::ADDR_CONTROL, 16'h0243 | {10'h000, lsb, 1'b0, cpol, cpha, 2'h0});
			send(8'h3C ^ 8'(m), ~(8'h3C ^ 8'(m))); // write starts
			chk("sent", {8'h00, ~p_tx}, {8'h00, p_rx}); // byte out
			chk("idle_clk", {15'h0000, cpol}, {15'h0000, sclk_out}); // idle level
			rdc("received", spicc_pkg::ADDR_RX, {8'h00, p_tx}); // byte in
		end
		chk("irq_set", 16'h0001, {15'h0000, irq}); // done event
		irqc("irq_mask", spicc_pkg::ADDR_IRQ_EN, 16'h0000, 1'b0); // masked
		irqc("irq_back", spicc_pkg::ADDR_IRQ_EN, 16'h0001, 1'b1); // sticky
		irqc("irq_clr", spicc_pkg::ADDR_IRQ_CLR, 16'h000F, 1'b0); // cleared
		irqc("irq_mode", spicc_pkg::ADDR_IRQ_EN, 16'h0008, 1'b1); // transmit empty
		rdc("status_tx", spicc_pkg::ADDR_STATUS, 16'h0002); // empty and irq bits
		// read-started frames with no new transmit data
		{lsb, cpol, cpha} = 3'h0;
		p_tx = 8'h5A;
		wr(spicc_pkg::ADDR_CONTROL, 16'h0283);
		rdc("rx_keep", spicc_pkg::ADDR_RX, 16'h003B); // read starts
		waitx;
		chk("resent", 16'h00C4, {8'h00, p_rx}); // repeat last
		chk("irq_rx", 16'h0001, {15'h0000, irq}); // receive full
		wr(spicc_pkg::ADDR_CONTROL, 16'h0203);
		rdc("rx_start", spicc_pkg::ADDR_RX, 16'h005A); // read starts
		waitx;
		chk("zero_fill", 16'h0000, {8'h00, p_rx}); // send zero
		// receive overflow, discard then overwrite
		wr(spicc_pkg::ADDR_CONTROL, 16'h0243);
		rdc("rx_clear", spicc_pkg::ADDR_RX, 16'h005A);
		send(8'h11, 8'h00);
		send(8'h22, 8'h00);
		rdc("discard", spicc_pkg::ADDR_RX, 16'h0011); // new byte dropped
		wr(spicc_pkg::ADDR_CONTROL, 16'h0343);
		send(8'h33, 8'h00);
		send(8'h44, 8'h00);
		rdc("overwrite", spicc_pkg::ADDR_RX, 16'h0044); // new byte kept
		chk("ss_on", 16'h0000, {15'h0000, ss_oe_n}); // select driven
		// disabled master starts nothing
		wr(spicc_pkg::ADDR_CONTROL, 16'h0042);
		wr(spicc_pkg::ADDR_TX, 16'h0077);
		repeat (10) @(posedge clk);
		chk("no_start", 16'h0001, {15'h0000, ss_n_out}); // stays idle
		chk("ss_off", 16'h0001, {15'h0000, ss_oe_n}); // select released
		// slave frame from the external master
		p_master = 1'b1;
		p_tx = 8'h69;
		wr(spicc_pkg::ADDR_CONTROL, 16'h0001);
		wr(spicc_pkg::ADDR_TX, 16'h0096);
		spicc_partner_inst.master_xfer;
		rdc("slave_rx", spicc_pkg::ADDR_RX, 16'h0069); // byte in
		chk("slave_tx", 16'h0096, {8'h00, p_rx}); // byte out
		conclude;
	end
endmodule

bind spicc_top spicc_assertions spicc_assertions_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_out(sclk_out),
	.sclk_oe_n(sclk_oe_n), .mosi_oe_n(mosi_oe_n), .ss_n_out(ss_n_out), .ss_oe_n(ss_oe_n), .irq(irq));
